// File: regulator_a_map.vh
// Purpose: Offsets, field positions, reset values and decode figures for
//          the regulator A setting register bank.
// Assumes: Included by its bare name from the design files.
// Notes:   Register indexes are byte address divided by four.
`ifndef REGULATOR_A_MAP_VH
`define REGULATOR_A_MAP_VH

// Register indexes (byte address = 4 * index)
`define IDX_PROCESSOR_BUCK_A 8'hA5
`define IDX_MEMORY_BUCK_A 8'hA6
`define IDX_IO_BUCK_A 8'hA7
`define IDX_PERIPHERAL_BUCK_A 8'hA8
`define IDX_FIRST_LDO_A 8'hA9
`define IDX_OPERATING_SELECT 8'hC0

// Field positions
`define SLEEP_BIT 7
`define LDO_RESERVED_BIT 6
`define BUCK_CODE_MSB 6
`define LDO_CODE_MSB 5
`define OPSEL_PROCESSOR_LSB 0
`define OPSEL_MEMORY_LSB 2
`define OPSEL_IO_LSB 4
`define OPSEL_PERIPHERAL_LSB 6

// Reset values
`define RESET_SETTING 8'h00
`define RESET_OPERATING_SELECT 8'h00

// Operating select field codes
`define OPSEL_FROM_SET 2'h0
`define OPSEL_SLEEP 2'h1
`define OPSEL_SYNC 2'h2
`define OPSEL_AUTO 2'h3

// Resolved operating mode codes
`define OP_SYNC 2'h0
`define OP_SLEEP 2'h1
`define OP_AUTO 2'h2

// Voltage decode figures in millivolts, and result width in bits
`define PROCESSOR_BASE_MV 530
`define PROCESSOR_STEP_MV 10
`define BUCK_BASE_MV 800
`define BUCK_STEP_MV 20
`define LDO_BASE_MV 600
`define LDO_STEP_MV 20
`define MV_WIDTH 12

`endif

// File: voltage_code_decoder.v
// Purpose: Turns a coded voltage field into millivolts, registered.
// Assumes: Linear code, base plus code times step.
// Notes:   Result held while clock_enable is low.
`timescale 1ns/1ps
`include "regulator_a_map.vh"

module voltage_code_decoder #(
  parameter CODE_W = 7,
  parameter BASE_MV = 800,
  parameter STEP_MV = 20,
  parameter OUT_W = `MV_WIDTH
) (
  // Clock and reset
  input wire clock,
  input wire nrst,
  input wire clock_enable,
  // Code in, millivolts out
  input wire [CODE_W-1:0] code,
  output reg [OUT_W-1:0] millivolts_q
);

  wire [31:0] code_ext;
  wire [31:0] sum_mv;

  assign code_ext = {{(32-CODE_W){1'b0}}, code};
  assign sum_mv = BASE_MV + STEP_MV * code_ext;

  always @(posedge clock) begin
    if (!nrst) begin
      millivolts_q <= {OUT_W{1'b0}};
    end else if (clock_enable) begin
      millivolts_q <= sum_mv[OUT_W-1:0];
    end
  end

endmodule

// File: regulator_a_settings.v
// Purpose: A setting registers for four bucks and the first LDO, reached
//          over Avalon-MM, with decoded voltages and resolved modes.
// Assumes: B set sleep bits come from on-chip logic on this clock; the
//          set select arrives on a pin and is synchronised.
// Notes:   Unmapped reads return zero, unmapped writes are dropped.
`timescale 1ns/1ps
`include "regulator_a_map.vh"

module regulator_a_settings (
  // Clock, reset, enable
  input wire clock,
  input wire nrst,
  input wire clock_enable,
  // Avalon-MM slave
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  // Set selection and B set sleep bits
  input wire set_b_select_pin,
  input wire [4:0] b_set_sleep_bits,
  // Resolved operating modes
  output reg [1:0] processor_buck_mode_q,
  output reg [1:0] memory_buck_mode_q,
  output reg [1:0] io_buck_mode_q,
  output reg [1:0] peripheral_buck_mode_q,
  output reg first_ldo_sleep_q,
  // Decoded A set voltages in millivolts
  output wire [11:0] processor_buck_a_mv,
  output wire [11:0] memory_buck_a_mv,
  output wire [11:0] io_buck_a_mv,
  output wire [11:0] peripheral_buck_a_mv,
  output wire [11:0] first_ldo_a_mv
);

  reg [7:0] processor_buck_a_setting_q;
  reg [7:0] memory_buck_a_setting_q;
  reg [7:0] io_buck_a_setting_q;
  reg [7:0] peripheral_buck_a_setting_q;
  reg [7:0] first_ldo_a_setting_q;
  reg [7:0] operating_select_q;
  reg set_b_sync1_q;
  reg set_b_sync2_q;
  reg [7:0] read_value_d;
  wire request;
  wire aligned;
  wire [7:0] index;
  wire write_hit;

  assign request = read | write;
  assign aligned = (address[1:0] == 2'h0);
  assign index = address[9:2];
  assign write_hit = write & ~waitrequest & byteenable[0] & aligned;

  // Pick sleep/sync/auto from a select field and the chosen set's bit
  function [1:0] resolve_mode;
    input [1:0] sel;
    input set_sleep;
    begin
      case (sel)
        `OPSEL_FROM_SET: resolve_mode = set_sleep ? `OP_SLEEP : `OP_SYNC;
        `OPSEL_SLEEP: resolve_mode = `OP_SLEEP;
        `OPSEL_SYNC: resolve_mode = `OP_SYNC;
        `OPSEL_AUTO: resolve_mode = `OP_AUTO;
        default: resolve_mode = `OP_SYNC;
      endcase
    end
  endfunction

  // Chosen set's sleep bit: A register bit or B set bit
  function chosen_sleep;
    input use_b;
    input a_bit;
    input b_bit;
    begin
      chosen_sleep = use_b ? b_bit : a_bit;
    end
  endfunction

  // Read mux
  always @* begin
    read_value_d = 8'h00;
    if (aligned) begin
      case (index)
        `IDX_PROCESSOR_BUCK_A: read_value_d = processor_buck_a_setting_q;
        `IDX_MEMORY_BUCK_A: read_value_d = memory_buck_a_setting_q;
        `IDX_IO_BUCK_A: read_value_d = io_buck_a_setting_q;
        `IDX_PERIPHERAL_BUCK_A: read_value_d = peripheral_buck_a_setting_q;
        `IDX_FIRST_LDO_A: read_value_d = first_ldo_a_setting_q;
        `IDX_OPERATING_SELECT: read_value_d = operating_select_q;
        default: read_value_d = 8'h00;
      endcase
    end
  end

  // Bus handshake: one wait cycle, then acknowledge
  always @(posedge clock) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end else if (clock_enable) begin
      if (request && waitrequest) begin
        waitrequest <= 1'b0;
        readdata <= {24'h000000, read_value_d};
      end else begin
        waitrequest <= 1'b1;
      end
    end
  end

  // Register writes, taken at the acknowledging edge
  always @(posedge clock) begin
    if (!nrst) begin
      processor_buck_a_setting_q <= `RESET_SETTING;
      memory_buck_a_setting_q <= `RESET_SETTING;
      io_buck_a_setting_q <= `RESET_SETTING;
      peripheral_buck_a_setting_q <= `RESET_SETTING;
      first_ldo_a_setting_q <= `RESET_SETTING;
      operating_select_q <= `RESET_OPERATING_SELECT;
    end else if (clock_enable && write_hit) begin
      case (index)
        `IDX_PROCESSOR_BUCK_A: processor_buck_a_setting_q <= writedata[7:0];
        `IDX_MEMORY_BUCK_A: memory_buck_a_setting_q <= writedata[7:0];
        `IDX_IO_BUCK_A: io_buck_a_setting_q <= writedata[7:0];
        `IDX_PERIPHERAL_BUCK_A: peripheral_buck_a_setting_q <= writedata[7:0];
        `IDX_FIRST_LDO_A: first_ldo_a_setting_q <= writedata[7:0];
        `IDX_OPERATING_SELECT: operating_select_q <= writedata[7:0];
        default: operating_select_q <= operating_select_q;
      endcase
    end
  end

  // Set select pin synchroniser
  always @(posedge clock) begin
    if (!nrst) begin
      set_b_sync1_q <= 1'b0;
      set_b_sync2_q <= 1'b0;
    end else if (clock_enable) begin
      set_b_sync1_q <= set_b_select_pin;
      set_b_sync2_q <= set_b_sync1_q;
    end
  end

  // Resolved operating modes; bit 6 of the LDO register is not read here
  always @(posedge clock) begin
    if (!nrst) begin
      processor_buck_mode_q <= `OP_SYNC;
      memory_buck_mode_q <= `OP_SYNC;
      io_buck_mode_q <= `OP_SYNC;
      peripheral_buck_mode_q <= `OP_SYNC;
      first_ldo_sleep_q <= 1'b0;
    end else if (clock_enable) begin
      processor_buck_mode_q <= resolve_mode(
        operating_select_q[`OPSEL_PROCESSOR_LSB+1:`OPSEL_PROCESSOR_LSB],
        chosen_sleep(set_b_sync2_q,
          processor_buck_a_setting_q[`SLEEP_BIT],
          b_set_sleep_bits[0]));
      memory_buck_mode_q <= resolve_mode(
        operating_select_q[`OPSEL_MEMORY_LSB+1:`OPSEL_MEMORY_LSB],
        chosen_sleep(set_b_sync2_q,
          memory_buck_a_setting_q[`SLEEP_BIT],
          b_set_sleep_bits[1]));
      io_buck_mode_q <= resolve_mode(
        operating_select_q[`OPSEL_IO_LSB+1:`OPSEL_IO_LSB],
        chosen_sleep(set_b_sync2_q,
          io_buck_a_setting_q[`SLEEP_BIT],
          b_set_sleep_bits[2]));
      peripheral_buck_mode_q <= resolve_mode(
        operating_select_q[`OPSEL_PERIPHERAL_LSB+1:`OPSEL_PERIPHERAL_LSB],
        chosen_sleep(set_b_sync2_q,
          peripheral_buck_a_setting_q[`SLEEP_BIT],
          b_set_sleep_bits[3]));
      first_ldo_sleep_q <= chosen_sleep(set_b_sync2_q,
        first_ldo_a_setting_q[`SLEEP_BIT],
        b_set_sleep_bits[4]);
    end
  end

  // Voltage decoders
  voltage_code_decoder #(
    .CODE_W(7),
    .BASE_MV(`PROCESSOR_BASE_MV),
    .STEP_MV(`PROCESSOR_STEP_MV),
    .OUT_W(`MV_WIDTH)
  ) processor_decoder (
    .clock(clock),
    .nrst(nrst),
    .clock_enable(clock_enable),
    .code(processor_buck_a_setting_q[`BUCK_CODE_MSB:0]),
    .millivolts_q(processor_buck_a_mv)
  );

  voltage_code_decoder #(
    .CODE_W(7),
    .BASE_MV(`BUCK_BASE_MV),
    .STEP_MV(`BUCK_STEP_MV),
    .OUT_W(`MV_WIDTH)
  ) memory_decoder (
    .clock(clock),
    .nrst(nrst),
    .clock_enable(clock_enable),
    .code(memory_buck_a_setting_q[`BUCK_CODE_MSB:0]),
    .millivolts_q(memory_buck_a_mv)
  );

  voltage_code_decoder #(
    .CODE_W(7),
    .BASE_MV(`BUCK_BASE_MV),
    .STEP_MV(`BUCK_STEP_MV),
    .OUT_W(`MV_WIDTH)
  ) io_decoder (
    .clock(clock),
    .nrst(nrst),
    .clock_enable(clock_enable),
    .code(io_buck_a_setting_q[`BUCK_CODE_MSB:0]),
    .millivolts_q(io_buck_a_mv)
  );

  voltage_code_decoder #(
    .CODE_W(7),
    .BASE_MV(`BUCK_BASE_MV),
    .STEP_MV(`BUCK_STEP_MV),
    .OUT_W(`MV_WIDTH)
  ) peripheral_decoder (
    .clock(clock),
    .nrst(nrst),
    .clock_enable(clock_enable),
    .code(peripheral_buck_a_setting_q[`BUCK_CODE_MSB:0]),
    .millivolts_q(peripheral_buck_a_mv)
  );

  voltage_code_decoder #(
    .CODE_W(6),
    .BASE_MV(`LDO_BASE_MV),
    .STEP_MV(`LDO_STEP_MV),
    .OUT_W(`MV_WIDTH)
  ) ldo_decoder (
    .clock(clock),
    .nrst(nrst),
    .clock_enable(clock_enable),
    .code(first_ldo_a_setting_q[`LDO_CODE_MSB:0]),
    .millivolts_q(first_ldo_a_mv)
  );

endmodule

// File: regulator_a_settings_monitor.sv
// Purpose: Bus and decode checks on regulator_a_settings
// Assumes: Bound to the top module ports, clock_enable held high
// Notes: Decoded outputs show an acknowledged write two edges later
`timescale 1ns/1ps
module reg_a_monitor (
  // Clock and reset
  input wire clock,
  input wire nrst,
  input wire clock_enable,
  // Bus
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  // Watched select pin and outputs
  input wire set_b_select_pin,
  input wire first_ldo_sleep_q,
  input wire [11:0] processor_buck_a_mv,
  input wire [11:0] memory_buck_a_mv,
  input wire [11:0] first_ldo_a_mv
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence ack_wr(a);
    clock_enable && write && !waitrequest && address == a && byteenable[0];
  endsequence
  sequence ldo_wr_a;
    (!set_b_select_pin)[*4] ##0 ack_wr(10'h2A4);
  endsequence
  a_req_acked: assert property (clock_enable && (read || write) &&
    waitrequest |=> !waitrequest) else $error("request not answered");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("acknowledge longer than one cycle");
  a_upper_zero: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_unmapped_zero: assert property (clock_enable && read && waitrequest &&
    address == 10'h3FC |=> readdata == 32'h0) else $error("unmapped read");
  a_proc_decode: assert property (ack_wr(10'h294) |-> ##2
    processor_buck_a_mv == 12'h212 + 12'hA * $past(writedata[6:0], 2))
    else $error("processor voltage decode");
  a_mem_decode: assert property (ack_wr(10'h298) |-> ##2
    memory_buck_a_mv == 12'h320 + 12'h14 * $past(writedata[6:0], 2))
    else $error("memory voltage decode");
  a_ldo_decode: assert property (ack_wr(10'h2A4) |-> ##2
    first_ldo_a_mv == 12'h258 + 12'h14 * $past(writedata[5:0], 2))
    else $error("ldo voltage decode");
  a_ldo_sleep: assert property (ldo_wr_a |-> ##2
    first_ldo_sleep_q == $past(writedata[7], 2))
    else $error("ldo sleep bit");
  a_be_drop: assert property (clock_enable && write && !waitrequest &&
    !byteenable[0] && address == 10'h2A4 |-> ##2 $stable(first_ldo_a_mv))
    else $error("masked write");
endmodule

// File: regulator_a_settings_bench.sv
// Purpose: Self-checking bench for regulator_a_settings
// Assumes: Model in the bench mirrors the six registers
// Notes: Outputs compared five cycles after the first write and after each loop readback
`timescale 1ns/1ps
module regulator_a_settings_bench;
  reg clock, nrst, set_b_select_pin, read, write;
  reg [9:0] address;
  reg [3:0] byteenable;
  reg [31:0] writedata, q;
  reg [4:0] b_set_sleep_bits;
  wire [31:0] readdata;
  wire waitrequest, l_sl;
  wire [1:0] p_md, m_md, i_md, r_md;
  wire [11:0] p_mv, m_mv, i_mv, r_mv, l_mv;
  integer n_fail = 0, cmp_count = 0, i, j;
  reg [7:0] m [0:5];
  reg [7:0] d;
  regulator_a_settings uut (.clock(clock), .nrst(nrst),
    .clock_enable(1'b1), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .set_b_select_pin(set_b_select_pin),
    .b_set_sleep_bits(b_set_sleep_bits), .processor_buck_mode_q(p_md),
    .memory_buck_mode_q(m_md), .io_buck_mode_q(i_md),
    .peripheral_buck_mode_q(r_md), .first_ldo_sleep_q(l_sl),
    .processor_buck_a_mv(p_mv), .memory_buck_a_mv(m_mv),
    .io_buck_a_mv(i_mv), .peripheral_buck_a_mv(r_mv),
    .first_ldo_a_mv(l_mv));
  function [1:0] em(input [1:0] s, input a, input b);
    begin
      if (s == 2'h0) em = (set_b_select_pin ? b : a) ? 2'h1 : 2'h0;
      else em = (s == 2'h1) ? 2'h1 : (s == 2'h2) ? 2'h0 : 2'h2;
    end
  endfunction
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (e !== g) begin
        n_fail = n_fail + 1;
        $display("FAIL %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [9:0] a, input [7:0] dd, input [3:0] be);
    begin
      @(posedge clock);
      address <= a;
      read <= !w;
      write <= w;
      writedata <= {24'h5A5A5A, dd};
      byteenable <= be;
      @(posedge clock);
      while (waitrequest !== 1'b0) @(posedge clock);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task wr(input integer k, input [7:0] dd, input [3:0] be);
    begin
      bus(1'b1, (k == 5) ? 10'h300 : 10'h294 + {k[7:0], 2'b00}, dd, be);
      if (be[0]) m[k] = dd;
    end
  endtask
  task rd(input integer k);
    begin
      bus(1'b0, (k == 5) ? 10'h300 : 10'h294 + {k[7:0], 2'b00}, 8'h00, 4'hF);
      chk("readback", {24'h0, m[k]}, q);
    end
  endtask
  task outs;
    begin
      repeat (5) @(posedge clock);
      chk("proc_mv", 530 + 10 * m[0][6:0], p_mv);
      chk("mem_mv", 800 + 20 * m[1][6:0], m_mv);
      chk("io_mv", 800 + 20 * m[2][6:0], i_mv);
      chk("peri_mv", 800 + 20 * m[3][6:0], r_mv);
      chk("ldo_mv", 600 + 20 * m[4][5:0], l_mv);
      chk("proc_md", em(m[5][1:0], m[0][7], b_set_sleep_bits[0]), p_md);
      chk("mem_md", em(m[5][3:2], m[1][7], b_set_sleep_bits[1]), m_md);
      chk("io_md", em(m[5][5:4], m[2][7], b_set_sleep_bits[2]), i_md);
      chk("peri_md", em(m[5][7:6], m[3][7], b_set_sleep_bits[3]), r_md);
      chk("ldo_sl", set_b_select_pin ? b_set_sleep_bits[4] : m[4][7], l_sl);
    end
  endtask
  task results;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    n_fail = n_fail + 1;
    results;
  end
  initial begin
    {nrst, read, write, set_b_select_pin} = 4'h0;
    address = 10'h000;
    byteenable = 4'hF;
    writedata = 32'h0;
    b_set_sleep_bits = 5'h00;
    j = $urandom(64);
    for (i = 0; i < 6; i = i + 1) m[i] = 8'h00;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 6; i = i + 1) rd(i);
    wr(0, 8'h11, 4'hF);
    outs;
    for (j = 0; j < 48; j = j + 1) begin
      d = (j < 6) ? 8'hFF : (j < 12) ? 8'h00 : $urandom % 256;
      set_b_select_pin <= $urandom % 2;
      b_set_sleep_bits <= $urandom % 32;
      wr(j % 6, d, 4'hF);
      rd(j % 6);
      outs;
    end
    wr(4, 8'h00, 4'hE);
    rd(4);
    bus(1'b0, 10'h3FC, 8'h00, 4'hF);
    chk("unmapped", 32'h0, q);
    bus(1'b0, 10'h295, 8'h00, 4'hF);
    chk("misalign", 32'h0, q);
    bus(1'b1, 10'h3FC, 8'hFF, 4'hF);
    for (i = 0; i < 6; i = i + 1) rd(i);
    nrst <= 1'b0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 6; i = i + 1) m[i] = 8'h00;
    rd(4);
    outs;
    results;
  end
endmodule
bind regulator_a_settings reg_a_monitor mon (.clock(clock), .nrst(nrst),
  .clock_enable(clock_enable), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .set_b_select_pin(set_b_select_pin),
  .first_ldo_sleep_q(first_ldo_sleep_q),
  .processor_buck_a_mv(processor_buck_a_mv),
  .memory_buck_a_mv(memory_buck_a_mv), .first_ldo_a_mv(first_ldo_a_mv));
